// >>> core/psb_cycle_decode.sv
`timescale 1ns/100ps
// What this block does
// - load read burst at external address
// - advance continues burst, keeps its type
// - read start with output disabled stays tristate
// - dummy read continuation steps, stays tristate
// - load write burst when lanes selected
// - continuation writes lanes selected that cycle
// - write start, no lanes: nothing written
// - write continuation, no lanes: step only
// - qualify high: edge ignored except by sleep sequencing
// - write cycle tristates whole data bus
// - output enable acts combinationally only
// - output enable masked during write data
// - drive only read, enabled and selected
// - powers up deselected, bus tristate
// - write needs strobe low and lane selected
// - strobe low, no lanes: no byte changes
// - each selected lane writes byte and parity
// - unselected load gives deselect, advance continues
// - write data captured two edges after start
// - burst order linear or interleaved, wraps
// - sleep overrides all, two cycles each way
module psb_cycle_decode (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    input  wire logic [psb_pkg::ADDR_W-1:0]  addr_in,
    input  wire psb_pkg::psb_ctl_t           ctl,
    input  wire logic                        out_enable_n,
    input  wire logic                        sleep_request,
    input  wire logic                        burst_order,
    input  wire psb_pkg::psb_word_t          bus_in,
    output psb_pkg::psb_word_t               bus_out,
    output logic                             bus_oe,
    output logic                             sleep_active
);

    psb_pkg::psb_cyc_t               burst_type_ff;
    psb_pkg::psb_cyc_t               nxt_burst_type;
    logic [psb_pkg::ADDR_W-1:0]      base_ff;
    logic [psb_pkg::ADDR_W-1:0]      nxt_base;
    logic [psb_pkg::BURST_W-1:0]     step_ff;
    logic [psb_pkg::BURST_W-1:0]     nxt_step;
    logic [psb_pkg::BURST_W-1:0]     step_inc;
    logic [psb_pkg::BURST_W-1:0]     burst_low;
    psb_pkg::psb_cyc_t               s1_type_ff;
    psb_pkg::psb_cyc_t               nxt_s1_type;
    logic [psb_pkg::ADDR_W-1:0]      s1_addr_ff;
    logic [psb_pkg::ADDR_W-1:0]      nxt_s1_addr;
    logic [psb_pkg::LANES-1:0]       s1_mask_ff;
    logic [psb_pkg::LANES-1:0]       nxt_s1_mask;
    logic                            s2_wr_ff;
    logic                            nxt_s2_wr;
    logic [psb_pkg::ADDR_W-1:0]      s2_addr_ff;
    logic [psb_pkg::ADDR_W-1:0]      nxt_s2_addr;
    logic [psb_pkg::LANES-1:0]       s2_mask_ff;
    logic [psb_pkg::LANES-1:0]       nxt_s2_mask;
    logic                            rd_drive_ff;
    logic                            nxt_rd_drive;
    psb_pkg::psb_word_t              rd_word_ff;
    psb_pkg::psb_word_t              nxt_rd_word;
    wire psb_pkg::psb_word_t         rd_word_now;
    psb_pkg::psb_slp_t               slp_state_ff;
    psb_pkg::psb_slp_t               nxt_slp_state;
    logic [psb_pkg::SLP_CNT_W-1:0]   slp_cnt_ff;
    logic [psb_pkg::SLP_CNT_W-1:0]   nxt_slp_cnt;
    logic                            sleep_active_ff;
    logic                            nxt_sleep_active;
    logic                            run;
    logic                            take_edge;
    logic                            cs_all;
    logic                            any_lane;

    // selection and cycle qualification
    assign cs_all    = ~ctl.chip_sel_n1 & ctl.chip_sel2 & ~ctl.chip_sel_n3;
    assign any_lane  = ~(&ctl.byte_lane_select_n);
    assign run       = (slp_state_ff == psb_pkg::PSB_SLP_AWAKE) & ~sleep_request;
    assign take_edge = run & ~ctl.clock_qualify_n;
    assign step_inc  = step_ff + psb_pkg::STEP_ONE;

    psb_burst_step u_burst_step (
        .base_low   (base_ff[psb_pkg::BURST_W-1:0]),
        .step       (step_inc),
        .interleave (burst_order),
        .addr_low   (burst_low)
    );

    // per-lane storage, byte plus parity
    genvar g;
    generate
        for (g = 0; g < psb_pkg::LANES; g = g + 1)
        begin : g_lane
            logic [psb_pkg::LANE_W:0] lane_mem [0:psb_pkg::DEPTH-1];

            always_ff @(posedge sys_clk)
            begin
                if (take_edge && s2_wr_ff && s2_mask_ff[g])
                begin
                    lane_mem[s2_addr_ff] <= {bus_in.parity[g],
                                             bus_in.data[g*psb_pkg::LANE_W +: psb_pkg::LANE_W]};
                end
            end

            assign rd_word_now.parity[g] = lane_mem[s1_addr_ff][psb_pkg::LANE_W];
            assign rd_word_now.data[g*psb_pkg::LANE_W +: psb_pkg::LANE_W] =
                lane_mem[s1_addr_ff][psb_pkg::LANE_W-1:0];
        end
    endgenerate

    // cycle decode and pipeline
    always_comb
    begin
        nxt_burst_type = burst_type_ff;
        nxt_base       = base_ff;
        nxt_step       = step_ff;
        nxt_s1_type    = s1_type_ff;
        nxt_s1_addr    = s1_addr_ff;
        nxt_s1_mask    = s1_mask_ff;
        nxt_s2_wr      = s2_wr_ff;
        nxt_s2_addr    = s2_addr_ff;
        nxt_s2_mask    = s2_mask_ff;
        nxt_rd_drive   = rd_drive_ff;
        nxt_rd_word    = rd_word_ff;
        if (!run)
        begin
            // sleep drops pending accesses
            nxt_burst_type = psb_pkg::PSB_CYC_IDLE;
            nxt_s1_type    = psb_pkg::PSB_CYC_IDLE;
            nxt_s2_wr      = 1'h0;
            nxt_rd_drive   = 1'h0;
        end
        else if (take_edge)
        begin
            nxt_rd_drive = (s1_type_ff == psb_pkg::PSB_CYC_READ);
            nxt_rd_word  = rd_word_now;
            nxt_s2_wr    = (s1_type_ff == psb_pkg::PSB_CYC_WRITE)
                           && (s1_mask_ff != psb_pkg::LANES_NONE);
            nxt_s2_addr  = s1_addr_ff;
            nxt_s2_mask  = s1_mask_ff;
            if (ctl.advance_or_load)
            begin
                // continue: chip selects and strobe ignored
                nxt_step    = step_inc;
                nxt_s1_type = burst_type_ff;
                nxt_s1_addr = {base_ff[psb_pkg::ADDR_W-1:psb_pkg::BURST_W], burst_low};
                nxt_s1_mask = ~ctl.byte_lane_select_n;
            end
            else if (cs_all)
            begin
                nxt_base    = addr_in;
                nxt_step    = psb_pkg::STEP_RST;
                nxt_s1_addr = addr_in;
                if (ctl.write_n)
                begin
                    nxt_s1_type = psb_pkg::PSB_CYC_READ;
                    nxt_s1_mask = psb_pkg::LANES_NONE;
                end
                else
                begin
                    nxt_s1_type = psb_pkg::PSB_CYC_WRITE;
                    nxt_s1_mask = ~ctl.byte_lane_select_n;
                end
                nxt_burst_type = nxt_s1_type;
            end
            else
            begin
                nxt_burst_type = psb_pkg::PSB_CYC_IDLE;
                nxt_s1_type    = psb_pkg::PSB_CYC_IDLE;
                nxt_s1_mask    = psb_pkg::LANES_NONE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            burst_type_ff <= psb_pkg::PSB_CYC_IDLE;
            base_ff       <= psb_pkg::ADDR_RST;
            step_ff       <= psb_pkg::STEP_RST;
            s1_type_ff    <= psb_pkg::PSB_CYC_IDLE;
            s1_addr_ff    <= psb_pkg::ADDR_RST;
            s1_mask_ff    <= psb_pkg::LANES_NONE;
            s2_wr_ff      <= 1'h0;
            s2_addr_ff    <= psb_pkg::ADDR_RST;
            s2_mask_ff    <= psb_pkg::LANES_NONE;
            rd_drive_ff   <= 1'h0;
            rd_word_ff    <= psb_pkg::WORD_RST;
        end
        else
        begin
            burst_type_ff <= nxt_burst_type;
            base_ff       <= nxt_base;
            step_ff       <= nxt_step;
            s1_type_ff    <= nxt_s1_type;
            s1_addr_ff    <= nxt_s1_addr;
            s1_mask_ff    <= nxt_s1_mask;
            s2_wr_ff      <= nxt_s2_wr;
            s2_addr_ff    <= nxt_s2_addr;
            s2_mask_ff    <= nxt_s2_mask;
            rd_drive_ff   <= nxt_rd_drive;
            rd_word_ff    <= nxt_rd_word;
        end
    end

    // sleep entry and exit sequencing
    always_comb
    begin
        nxt_slp_state = slp_state_ff;
        nxt_slp_cnt   = slp_cnt_ff;
        unique case (slp_state_ff)
            psb_pkg::PSB_SLP_AWAKE:
            begin
                if (sleep_request)
                begin
                    nxt_slp_state = psb_pkg::PSB_SLP_ENTER;
                    nxt_slp_cnt   = psb_pkg::SLP_ONE;
                end
            end
            psb_pkg::PSB_SLP_ENTER:
            begin
                if (!sleep_request)
                begin
                    nxt_slp_state = psb_pkg::PSB_SLP_AWAKE;
                    nxt_slp_cnt   = psb_pkg::SLP_CNT_RST;
                end
                else if (slp_cnt_ff == psb_pkg::SLP_LAST)
                begin
                    nxt_slp_state = psb_pkg::PSB_SLP_ASLEEP;
                    nxt_slp_cnt   = psb_pkg::SLP_CNT_RST;
                end
                else
                begin
                    nxt_slp_cnt = slp_cnt_ff + psb_pkg::SLP_ONE;
                end
            end
            psb_pkg::PSB_SLP_ASLEEP:
            begin
                if (!sleep_request)
                begin
                    nxt_slp_state = psb_pkg::PSB_SLP_WAKE;
                    nxt_slp_cnt   = psb_pkg::SLP_ONE;
                end
            end
            psb_pkg::PSB_SLP_WAKE:
            begin
                if (sleep_request)
                begin
                    nxt_slp_state = psb_pkg::PSB_SLP_ENTER;
                    nxt_slp_cnt   = psb_pkg::SLP_ONE;
                end
                else if (slp_cnt_ff == psb_pkg::SLP_LAST)
                begin
                    nxt_slp_state = psb_pkg::PSB_SLP_AWAKE;
                    nxt_slp_cnt   = psb_pkg::SLP_CNT_RST;
                end
                else
                begin
                    nxt_slp_cnt = slp_cnt_ff + psb_pkg::SLP_ONE;
                end
            end
            default:
            begin
                nxt_slp_state = psb_pkg::PSB_SLP_AWAKE;
                nxt_slp_cnt   = psb_pkg::SLP_CNT_RST;
            end
        endcase
        nxt_sleep_active = (nxt_slp_state != psb_pkg::PSB_SLP_AWAKE);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slp_state_ff    <= psb_pkg::PSB_SLP_AWAKE;
            slp_cnt_ff      <= psb_pkg::SLP_CNT_RST;
            sleep_active_ff <= 1'h0;
        end
        else
        begin
            slp_state_ff    <= nxt_slp_state;
            slp_cnt_ff      <= nxt_slp_cnt;
            sleep_active_ff <= nxt_sleep_active;
        end
    end

    // bus enable stays unclocked on purpose
    assign bus_oe       = rd_drive_ff & ~out_enable_n
                          & ~s2_wr_ff & ~sleep_request;
    assign bus_out      = rd_word_ff;
    assign sleep_active = sleep_active_ff;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_read_start;
        take_edge && !ctl.advance_or_load && cs_all && ctl.write_n;
    endsequence

    sequence s_write_start;
        take_edge && !ctl.advance_or_load && cs_all && !ctl.write_n && any_lane;
    endsequence

    property p_stall_hold;
        run && ctl.clock_qualify_n |=> $stable(s1_addr_ff) && $stable(step_ff)
            && $stable(rd_drive_ff) && $stable(s2_wr_ff);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stall changed state");

    property p_read_start;
        s_read_start |=> s1_type_ff == psb_pkg::PSB_CYC_READ && s1_addr_ff == $past(addr_in);
    endproperty
    a_read_start: assert property (p_read_start) else $error("read start not loaded");

    property p_read_latency;
        s_read_start ##1 take_edge |=> rd_drive_ff;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read data late");

    property p_write_release;
        s_write_start ##1 take_edge |=> s2_wr_ff && !bus_oe;
    endproperty
    a_write_release: assert property (p_write_release) else $error("write not released");

    property p_write_start;
        s_write_start |=> s1_type_ff == psb_pkg::PSB_CYC_WRITE
            && s1_mask_ff == ~$past(ctl.byte_lane_select_n);
    endproperty
    a_write_start: assert property (p_write_start) else $error("write start wrong");

    property p_abort;
        take_edge && s1_type_ff == psb_pkg::PSB_CYC_WRITE
            && s1_mask_ff == psb_pkg::LANES_NONE |=> !s2_wr_ff;
    endproperty
    a_abort: assert property (p_abort) else $error("aborted write stored");

    property p_continue;
        take_edge && ctl.advance_or_load |=> s1_type_ff == $past(burst_type_ff)
            && step_ff == $past(step_inc);
    endproperty
    a_continue: assert property (p_continue) else $error("burst continue wrong");

    property p_deselect;
        take_edge && !ctl.advance_or_load && !cs_all |=> s1_type_ff == psb_pkg::PSB_CYC_IDLE
            && burst_type_ff == psb_pkg::PSB_CYC_IDLE;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect not taken");

    property p_write_mask;
        take_edge && s1_type_ff == psb_pkg::PSB_CYC_WRITE |=> !bus_oe && !rd_drive_ff;
    endproperty
    a_write_mask: assert property (p_write_mask) else $error("bus driven in write");

    property p_dummy;
        rd_drive_ff && out_enable_n |-> !bus_oe;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy read drove bus");

    property p_sleep_enter;
        sleep_request [*2] |=> slp_state_ff == psb_pkg::PSB_SLP_ASLEEP && sleep_active;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry late");

endmodule

// >>> shared/psb_pkg.sv
package psb_pkg;

    localparam int ADDR_W  = 17;
    localparam int DEPTH   = 1 << ADDR_W;
    localparam int LANES   = 4;
    localparam int LANE_W  = 8;
    localparam int DATA_W  = LANES * LANE_W;
    localparam int BURST_W = 2;

    // sleep entry and exit take this many clock cycles
    localparam int SLEEP_CYCLES = 2;
    localparam int SLP_CNT_W    = 2;

    localparam logic [SLP_CNT_W-1:0] SLP_CNT_RST = 2'h0;
    localparam logic [SLP_CNT_W-1:0] SLP_ONE     = 2'h1;
    localparam logic [SLP_CNT_W-1:0] SLP_LAST    = SLP_CNT_W'(SLEEP_CYCLES - 1);

    localparam logic [ADDR_W-1:0]  ADDR_RST   = 17'h0_0000;
    localparam logic [BURST_W-1:0] STEP_RST   = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE   = 2'h1;
    localparam logic [LANES-1:0]   LANES_NONE = 4'h0;

    typedef enum logic [2:0] {
        PSB_CYC_IDLE  = 3'h1,
        PSB_CYC_READ  = 3'h2,
        PSB_CYC_WRITE = 3'h4
    } psb_cyc_t;

    typedef enum logic [3:0] {
        PSB_SLP_AWAKE  = 4'h1,
        PSB_SLP_ENTER  = 4'h2,
        PSB_SLP_ASLEEP = 4'h4,
        PSB_SLP_WAKE   = 4'h8
    } psb_slp_t;

    typedef struct packed {
        logic             chip_sel_n1;
        logic             chip_sel2;
        logic             chip_sel_n3;
        logic             advance_or_load;
        logic             write_n;
        logic [LANES-1:0] byte_lane_select_n;
        logic             clock_qualify_n;
    } psb_ctl_t;

    typedef struct packed {
        logic [LANES-1:0]  parity;
        logic [DATA_W-1:0] data;
    } psb_word_t;

    localparam psb_word_t WORD_RST = 36'h0_0000_0000;

endpackage

// >>> core/psb_burst_step.sv
`timescale 1ns/100ps
module psb_burst_step (
    input  wire logic [psb_pkg::BURST_W-1:0] base_low,
    input  wire logic [psb_pkg::BURST_W-1:0] step,
    input  wire logic                        interleave,
    output logic      [psb_pkg::BURST_W-1:0] addr_low
);

    // two low address bits, wrapping
    always_comb
    begin
        if (interleave)
        begin
            addr_low = base_low ^ step;
        end
        else
        begin
            addr_low = base_low + step;
        end
    end

endmodule

// >>> bench/psb_ctrl_model.sv
`timescale 1ns/100ps
module psb_ctrl_model (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic               clock_qualify_n,
    input  wire logic               data_req,
    input  wire psb_pkg::psb_word_t data_word,
    output psb_pkg::psb_word_t      bus_in
);
    logic               req_d1_ff;
    logic               req_d2_ff;
    psb_pkg::psb_word_t word_d1_ff;
    psb_pkg::psb_word_t word_d2_ff;
    psb_pkg::psb_word_t last_ff;

    // write data goes out two qualified edges after its cycle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_d1_ff  <= 1'b0;
            req_d2_ff  <= 1'b0;
            word_d1_ff <= psb_pkg::WORD_RST;
            word_d2_ff <= psb_pkg::WORD_RST;
            last_ff    <= psb_pkg::WORD_RST;
        end
        else if (!clock_qualify_n)
        begin
            req_d1_ff  <= data_req;
            word_d1_ff <= data_word;
            req_d2_ff  <= req_d1_ff;
            word_d2_ff <= word_d1_ff;
            if (req_d2_ff)
                last_ff <= word_d2_ff;
        end
    end

    // released bus shows the inverse of the last word
    assign bus_in = req_d2_ff ? word_d2_ff : ~last_ff;
endmodule

// >>> bench/pipelined_burst_sram_cycle_decode_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pipelined_burst_sram_cycle_decode_tb_top;
    logic                       sys_clk;
    logic                       rst_b;
    logic                       out_enable_n;
    logic                       sleep_request;
    logic                       burst_order;
    logic                       data_req;
    logic                       bus_oe;
    logic                       sleep_active;
    logic [psb_pkg::ADDR_W-1:0] addr_in;
    psb_pkg::psb_ctl_t          ctl;
    psb_pkg::psb_word_t         bus_in;
    psb_pkg::psb_word_t         bus_out;
    psb_pkg::psb_word_t         data_word;
    psb_pkg::psb_word_t         mem [int];
    int                         failures;
    int                         comparisons;

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    psb_cycle_decode uut (.sys_clk(sys_clk), .rst_b(rst_b), .addr_in(addr_in), .ctl(ctl),
        .out_enable_n(out_enable_n), .sleep_request(sleep_request),
        .burst_order(burst_order), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
        .sleep_active(sleep_active));

    psb_ctrl_model partner (.sys_clk(sys_clk), .rst_b(rst_b),
        .clock_qualify_n(ctl.clock_qualify_n), .data_req(data_req),
        .data_word(data_word), .bus_in(bus_in));

    function automatic logic [16:0] baddr(input logic [16:0] a, input int k, input logic ord);
        return {a[16:2], ord ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k))};
    endfunction

    function automatic psb_pkg::psb_word_t pat(input int i);
        return {4'(i), 32'h5a5a_0000 + 32'(i) * 32'h0000_0101};
    endfunction

    task automatic cyc(input logic ld, input logic wr, input logic [16:0] a,
                       input logic [3:0] ln, input logic dq, input psb_pkg::psb_word_t d,
                       input logic [2:0] cs = 3'h2, input logic qn = 1'b0);
        @(negedge sys_clk);
        {ctl.chip_sel_n1, ctl.chip_sel2, ctl.chip_sel_n3} = cs;
        ctl.advance_or_load    = ~ld;
        ctl.write_n            = ~wr;
        ctl.byte_lane_select_n = ln;
        ctl.clock_qualify_n    = qn;
        addr_in                = a;
        data_req               = dq;
        data_word              = d;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic idle();
        cyc(1'b1, 1'b0, 17'h0_0000, 4'hf, 1'b0, psb_pkg::WORD_RST, 3'h7);
    endtask

    task automatic wburst(input logic [16:0] a, input logic [3:0] ln [4], input int base);
        psb_pkg::psb_word_t w;
        logic [16:0]        wa;
        for (int k = 0; k < 4; k++)
        begin
            w  = pat(base + k);
            wa = baddr(a, k, burst_order);
            cyc(k == 0, 1'b1, a, ln[k], 1'b1, w);
            `CHK(bus_oe, 1'b0)
            for (int j = 0; j < 4; j++)
                if (!ln[k][j])
                begin
                    mem[wa][8*j +: 8]  = w.data[8*j +: 8];
                    mem[wa].parity[j]  = w.parity[j];
                end
        end
        idle();
        idle();
    endtask

    task automatic rburst(input logic [16:0] a, input logic oen);
        @(negedge sys_clk);
        out_enable_n = oen;
        cyc(1'b1, 1'b0, a, 4'hf, 1'b0, psb_pkg::WORD_RST);
        for (int k = 0; k < 4; k++)
        begin
            if (k < 3)
                cyc(1'b0, 1'b0, 17'h1_ffff, 4'h0, 1'b0, psb_pkg::WORD_RST, 3'h7);
            else
                idle();
            if (oen)
                `CHK(bus_oe, 1'b0)
            if (oen && k == 3)
            begin
                @(negedge sys_clk);
                out_enable_n = 1'b0;
                #1;
                `CHK(bus_oe, 1'b1)
            end
            if (!out_enable_n)
            begin
                `CHK(bus_oe, 1'b1)
                `CHK(bus_out, mem[baddr(a, k, burst_order)])
            end
        end
        idle();
        `CHK(bus_oe, 1'b0)
    endtask

    task automatic test_done();
        $display("counts comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        test_done();
    end

    initial
    begin
        failures = 0;
        comparisons = 0;
        rst_b = 1'b0;
        out_enable_n = 1'b0;
        sleep_request = 1'b0;
        burst_order = 1'b0;
        data_req = 1'b0;
        data_word = psb_pkg::WORD_RST;
        addr_in = 17'h0_0000;
        ctl = '1;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK(bus_oe, 1'b0)
        `CHK(sleep_active, 1'b0)
        @(negedge sys_clk);
        rst_b = 1'b1;
        $display("test reset done");
        wburst(17'h0_0010, '{4'h0, 4'h0, 4'h0, 4'h0}, 0);
        wburst(17'h0_0022, '{4'h0, 4'h0, 4'h0, 4'h0}, 8);
        rburst(17'h0_0010, 1'b0);
        rburst(17'h0_0022, 1'b0);
        $display("test linear burst done");
        wburst(17'h0_0012, '{4'hf, 4'ha, 4'hf, 4'h5}, 16);
        rburst(17'h0_0010, 1'b0);
        $display("test byte lanes done");
        @(negedge sys_clk);
        burst_order = 1'b1;
        rburst(17'h0_0011, 1'b0);
        rburst(17'h0_0023, 1'b1);
        @(negedge sys_clk);
        burst_order = 1'b0;
        $display("test interleave and dummy read done");
        for (int i = 0; i < 3; i++)
        begin
            cyc(1'b1, 1'b0, 17'h0_0010, 4'hf, 1'b0, psb_pkg::WORD_RST, 3'h2 ^ (3'h4 >> i));
            cyc(1'b0, 1'b0, 17'h0_0010, 4'hf, 1'b0, psb_pkg::WORD_RST);
            `CHK(bus_oe, 1'b0)
            cyc(1'b0, 1'b0, 17'h0_0010, 4'hf, 1'b0, psb_pkg::WORD_RST);
            `CHK(bus_oe, 1'b0)
        end
        $display("test deselect done");
        cyc(1'b1, 1'b0, 17'h0_0010, 4'hf, 1'b0, psb_pkg::WORD_RST);
        repeat (2) cyc(1'b1, 1'b1, 17'h0_0013, 4'h0, 1'b0, psb_pkg::WORD_RST, 3'h2, 1'b1);
        `CHK(bus_oe, 1'b0)
        idle();
        `CHK(bus_oe, 1'b1)
        `CHK(bus_out, mem[17'h0_0010])
        cyc(1'b1, 1'b1, 17'h0_0013, 4'h0, 1'b0, psb_pkg::WORD_RST, 3'h2, 1'b1);
        `CHK(bus_oe, 1'b1)
        `CHK(bus_out, mem[17'h0_0010])
        idle();
        `CHK(bus_oe, 1'b0)
        $display("test stall done");
        cyc(1'b1, 1'b0, 17'h0_0011, 4'hf, 1'b0, psb_pkg::WORD_RST);
        idle();
        @(negedge sys_clk);
        sleep_request = 1'b1;
        #1;
        `CHK(bus_oe, 1'b0)
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(sleep_active, 1'b1)
        @(negedge sys_clk);
        sleep_request = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(sleep_active, 1'b0)
        rburst(17'h0_0020, 1'b0);
        $display("test sleep done");
        test_done();
    end
endmodule
